// ===== core/ncbo_regs.svh
/*
  Register offsets, field positions and reset values of the negate,
  compare and bit-operation datapath slice.
  Assumes a 9-bit byte address on the plain register port; bit 8 set
  selects the data-memory window.
*/
`ifndef NCBO_REGS_SVH
`define NCBO_REGS_SVH

`define NCBO_REG_FLAGS             9'h000
`define NCBO_REG_FIRST_PORT_DATA   9'h001
`define NCBO_REG_SECOND_PORT_DATA  9'h002
`define NCBO_REG_FIRST_PORT_DIR    9'h003
`define NCBO_REG_SECOND_PORT_DIR   9'h004
`define NCBO_REG_FIRST_PORT_PIN    9'h005
`define NCBO_REG_SECOND_PORT_PIN   9'h006
`define NCBO_REG_STATUS            9'h007

`define NCBO_MEM_WIN_BIT           8
`define NCBO_STATUS_BUSY_BIT       0
`define NCBO_STATUS_DONE_BIT       1

`define NCBO_FLAGS_RST             4'h0
`define NCBO_PORT_RST              8'h00
`define NCBO_DIR_RST               8'h00

`endif

// ===== core/ncbo_pkg.sv
/*
  Types shared by the datapath slice: operation codes, the command
  carried from the decoder, the flag word and the sequencer states.
  Assumes the decoder supplies one command at a time.
*/
package ncbo_pkg;

  localparam int NCBO_NPORT = 2;

  typedef enum logic [3:0] {
    OP_NOP                   = 4'b0000,
    OP_NEG_MEM               = 4'b0001,
    OP_CMP_REG_MEM           = 4'b0010,
    OP_CMP_MEM_REG           = 4'b0011,
    OP_BIT_FORCE_HIGH_OP_MEM = 4'b0100,
    OP_BIT_CLEAR_OP_MEM      = 4'b0101,
    OP_BIT_CLEAR_OP_IO       = 4'b0110,
    OP_BIT_FORCE_HIGH_OP_IO  = 4'b0111,
    OP_IO_SWAP_CARRY         = 4'b1000
  } ncbo_op_t;

  typedef struct packed {
    ncbo_op_t   op;
    logic       port_sel;
    logic [2:0] bit_sel;
    logic [7:0] mem_addr;
    logic [7:0] working_register;
  } ncbo_cmd_t;

  typedef struct packed {
    logic signed_range_flag;
    logic half_carry_flag;
    logic carry;
    logic zero;
  } ncbo_flags_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } ncbo_state_t;

endpackage

// ===== core/ncbo_ram.sv
/*
  Small data memory: one write port, two read ports whose data come
  out of registers one cycle after the address.
  Assumes both users sit on the same clock.
*/
`timescale 1ns/10ps

module ncbo_ram #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic      [DW-1:0] rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [DW-1:0] rdata_b
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  if (AW < 1 || AW > 8) begin : g_bad_aw
    $error("ncbo_ram: AW must be 1 to 8");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end

endmodule // ncbo_ram

// ===== core/ncbo_core.sv
/*
  Execution slice for negate-memory, the two compare forms and the
  single-bit operations on I/O port bits and memory bits, with the two
  I/O ports, their direction registers, the flag register and a plain
  register port.
  Assumes the decoder holds CMD stable while CMD_VALID is high and
  CMD_READY is low, and that pin inputs are asynchronous.
*/
`timescale 1ns/10ps
`include "ncbo_regs.svh"

// Function
// - negate-memory writes the two's complement back and updates only zero.
// - compare register-first flags working register minus memory, no write.
// - compare memory-first flags memory minus working register, no write.
// - in a compare carry is a borrow and zero marks equal operands.
// - I/O bit clear drives the chosen port bit low, other bits and flags kept.
// - I/O bit set drives the chosen port bit high, other bits and flags kept.
// - I/O carry swap exchanges the port bit and carry, touching only carry.
// - on an output bit the swap puts the old carry into the port bit.
// - on an input bit the swap loads the synchronised pin level into carry.
// - memory bit set forces the chosen bit high, others and flags kept.
module ncbo_core
  import ncbo_pkg::*;
#(
  parameter int MEM_AW = 6
) (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic                        CMD_VALID,
  input  wire ncbo_cmd_t                   CMD,
  output logic                             CMD_READY,
  output logic                             DONE,
  output ncbo_flags_t                      FLAGS,
  input  wire logic [8:0]                  BUS_ADDR,
  input  wire logic [7:0]                  BUS_WDATA,
  input  wire logic                        BUS_WR,
  input  wire logic                        BUS_RD,
  output logic      [7:0]                  BUS_RDATA,
  input  wire logic [NCBO_NPORT-1:0][7:0]  PIN_IN,
  output logic      [NCBO_NPORT-1:0][7:0]  PIN_OUT,
  output logic      [NCBO_NPORT-1:0][7:0]  PIN_OE
);

  ncbo_state_t                  state_reg;
  ncbo_cmd_t                    cmd_reg;
  ncbo_flags_t                  flags_reg;
  ncbo_flags_t                  flags_next;
  logic                         done_reg;
  logic                         take;
  logic                         is_mem_op;
  logic                         is_io_op;
  logic                         exec;
  logic                         flag_bus_wr;
  logic                         eng_wr;
  logic      [7:0]              eng_wdata;
  logic      [7:0]              mem_rdata;
  logic      [7:0]              bus_mem_rdata;
  logic      [7:0]              mask_take;
  logic      [7:0]              mask_exec;
  logic      [7:0]              minuend;
  logic      [7:0]              subtrahend;
  logic      [8:0]              diff;
  logic                         swap_src;
  logic                         bus_mem_wr;
  logic                         rd_mem_reg;
  logic      [7:0]              bus_rdata_reg;
  logic      [7:0]              reg_rdata_next;
  logic [NCBO_NPORT-1:0][7:0]   port_q;
  logic [NCBO_NPORT-1:0][7:0]   dir_q;
  logic [NCBO_NPORT-1:0][7:0]   pin_q;

  if (MEM_AW < 1 || MEM_AW > 8) begin : g_bad_aw
    $error("ncbo_core: MEM_AW must be 1 to 8");
  end

  assign exec        = (state_reg == ST_EXEC);
  assign CMD_READY   = (state_reg == ST_IDLE);
  assign take        = CMD_VALID && CMD_READY;
  assign is_mem_op   = CMD.op inside {OP_NEG_MEM, OP_CMP_REG_MEM,
                       OP_CMP_MEM_REG, OP_BIT_FORCE_HIGH_OP_MEM,
                       OP_BIT_CLEAR_OP_MEM};
  assign is_io_op    = CMD.op inside {OP_BIT_CLEAR_OP_IO,
                       OP_BIT_FORCE_HIGH_OP_IO, OP_IO_SWAP_CARRY};
  assign mask_take   = 8'h01 << CMD.bit_sel;
  assign mask_exec   = 8'h01 << cmd_reg.bit_sel;
  assign flag_bus_wr = BUS_WR && (BUS_ADDR == `NCBO_REG_FLAGS);
  assign DONE        = done_reg;
  assign FLAGS       = flags_reg;

  // memory operations read in the take cycle and finish one cycle later
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= (take && is_mem_op) ? ST_EXEC : ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_reg <= '0;
    end else if (take) begin
      cmd_reg <= CMD;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (take && !is_mem_op) || exec;
    end
  end

  // operand order of the subtraction follows the compare form
  always_comb begin
    minuend    = cmd_reg.working_register;
    subtrahend = mem_rdata;
    if (cmd_reg.op == OP_CMP_MEM_REG) begin
      minuend    = mem_rdata;
      subtrahend = cmd_reg.working_register;
    end
    diff = {1'b0, minuend} - {1'b0, subtrahend};
  end

  always_comb begin
    eng_wr    = 1'b0;
    eng_wdata = mem_rdata;
    if (exec) begin
      case (cmd_reg.op)
        OP_NEG_MEM: begin
          eng_wr    = 1'b1;
          eng_wdata = 8'h00 - mem_rdata;
        end
        OP_BIT_FORCE_HIGH_OP_MEM: begin
          eng_wr    = 1'b1;
          eng_wdata = mem_rdata | mask_exec;
        end
        OP_BIT_CLEAR_OP_MEM: begin
          eng_wr    = 1'b1;
          eng_wdata = mem_rdata & ~mask_exec;
        end
        default: begin
          eng_wr    = 1'b0;
        end
      endcase
    end
  end

  // carry source of the swap depends on the bit's direction
  assign swap_src = dir_q[CMD.port_sel][CMD.bit_sel]
                  ? port_q[CMD.port_sel][CMD.bit_sel]
                  : pin_q[CMD.port_sel][CMD.bit_sel];

  // datapath updates override a software write in the same cycle
  always_comb begin
    flags_next = flags_reg;
    if (flag_bus_wr) begin
      flags_next = ncbo_flags_t'(BUS_WDATA[3:0]);
    end
    if (exec && cmd_reg.op == OP_NEG_MEM) begin
      flags_next.zero = (eng_wdata == 8'h00);
    end
    if (exec && (cmd_reg.op == OP_CMP_REG_MEM ||
                 cmd_reg.op == OP_CMP_MEM_REG)) begin
      flags_next.zero              = (diff[7:0] == 8'h00);
      flags_next.carry             = diff[8];
      flags_next.half_carry_flag   = minuend[3:0] < subtrahend[3:0];
      flags_next.signed_range_flag = (minuend[7] ^ subtrahend[7]) &
                                     (minuend[7] ^ diff[7]);
    end
    if (take && CMD.op == OP_IO_SWAP_CARRY) begin
      flags_next.carry = swap_src;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_reg <= ncbo_flags_t'(`NCBO_FLAGS_RST);
    end else begin
      flags_reg <= flags_next;
    end
  end

  for (genvar p = 0; p < NCBO_NPORT; p++) begin : g_port
    localparam logic [8:0] DATA_ADDR = (p == 0) ?
      `NCBO_REG_FIRST_PORT_DATA : `NCBO_REG_SECOND_PORT_DATA;
    localparam logic [8:0] DIR_ADDR = (p == 0) ?
      `NCBO_REG_FIRST_PORT_DIR : `NCBO_REG_SECOND_PORT_DIR;
    logic [7:0] meta_reg;
    logic [7:0] pin_reg;
    logic [7:0] data_reg;
    logic [7:0] dir_reg;
    logic       hit;

    assign hit = take && is_io_op && (CMD.port_sel == 1'(p));

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        meta_reg <= 8'h00;
        pin_reg  <= 8'h00;
      end else begin
        meta_reg <= PIN_IN[p];
        pin_reg  <= meta_reg;
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        data_reg <= `NCBO_PORT_RST;
      end else if (hit) begin
        case (CMD.op)
          OP_BIT_CLEAR_OP_IO: begin
            data_reg <= data_reg & ~mask_take;
          end
          OP_BIT_FORCE_HIGH_OP_IO: begin
            data_reg <= data_reg | mask_take;
          end
          default: begin
            data_reg <= (data_reg & ~mask_take) |
                        (flags_reg.carry ? mask_take : 8'h00);
          end
        endcase
      end else if (BUS_WR && BUS_ADDR == DATA_ADDR) begin
        data_reg <= BUS_WDATA;
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        dir_reg <= `NCBO_DIR_RST;
      end else if (BUS_WR && BUS_ADDR == DIR_ADDR) begin
        dir_reg <= BUS_WDATA;
      end
    end

    assign port_q[p] = data_reg;
    assign dir_q[p]  = dir_reg;
    assign pin_q[p]  = pin_reg;
  end

  assign PIN_OUT = port_q;
  assign PIN_OE  = dir_q;

  // the datapath write wins the single write port
  assign bus_mem_wr = BUS_WR && BUS_ADDR[`NCBO_MEM_WIN_BIT] && !eng_wr;

  ncbo_ram #(
    .AW (MEM_AW),
    .DW (8)
  ) u_ram (
    .clk     (CLK),
    .rst_n   (RST_N),
    .we      (eng_wr || bus_mem_wr),
    .waddr   (eng_wr ? cmd_reg.mem_addr[MEM_AW-1:0]
                     : BUS_ADDR[MEM_AW-1:0]),
    .wdata   (eng_wr ? eng_wdata : BUS_WDATA),
    .raddr_a (CMD.mem_addr[MEM_AW-1:0]),
    .rdata_a (mem_rdata),
    .raddr_b (BUS_ADDR[MEM_AW-1:0]),
    .rdata_b (bus_mem_rdata)
  );

  always_comb begin
    reg_rdata_next = 8'h00;
    if (BUS_ADDR == `NCBO_REG_FLAGS) begin
      reg_rdata_next = {4'h0, flags_reg};
    end else if (BUS_ADDR == `NCBO_REG_FIRST_PORT_DATA) begin
      reg_rdata_next = port_q[0];
    end else if (BUS_ADDR == `NCBO_REG_SECOND_PORT_DATA) begin
      reg_rdata_next = port_q[1];
    end else if (BUS_ADDR == `NCBO_REG_FIRST_PORT_DIR) begin
      reg_rdata_next = dir_q[0];
    end else if (BUS_ADDR == `NCBO_REG_SECOND_PORT_DIR) begin
      reg_rdata_next = dir_q[1];
    end else if (BUS_ADDR == `NCBO_REG_FIRST_PORT_PIN) begin
      reg_rdata_next = pin_q[0];
    end else if (BUS_ADDR == `NCBO_REG_SECOND_PORT_PIN) begin
      reg_rdata_next = pin_q[1];
    end else if (BUS_ADDR == `NCBO_REG_STATUS) begin
      reg_rdata_next[`NCBO_STATUS_BUSY_BIT] = exec;
      reg_rdata_next[`NCBO_STATUS_DONE_BIT] = done_reg;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_mem_reg    <= 1'b0;
      bus_rdata_reg <= 8'h00;
    end else begin
      rd_mem_reg    <= BUS_RD && BUS_ADDR[`NCBO_MEM_WIN_BIT];
      bus_rdata_reg <= (BUS_RD && !BUS_ADDR[`NCBO_MEM_WIN_BIT])
                     ? reg_rdata_next : 8'h00;
    end
  end

  assign BUS_RDATA = rd_mem_reg ? bus_mem_rdata : bus_rdata_reg;

  // helper: selected port value before an I/O operation
  logic [7:0] chk_port_before;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chk_port_before <= 8'h00;
    end else begin
      chk_port_before <= port_q[CMD.port_sel];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_NEG_WRITE: assert property (
    exec && cmd_reg.op == OP_NEG_MEM |->
      eng_wr && (8'(eng_wdata + mem_rdata) == 8'h00))
    else $error("negate did not write the two's complement");
  AST_NEG_FLAGS: assert property (
    exec && cmd_reg.op == OP_NEG_MEM && !flag_bus_wr |=>
      flags_reg.zero == ($past(mem_rdata) == 8'h00) &&
      $stable(flags_reg.carry) && $stable(flags_reg.half_carry_flag) &&
      $stable(flags_reg.signed_range_flag))
    else $error("negate flags wrong");
  AST_CMP_REG_FIRST: assert property (
    exec && cmd_reg.op == OP_CMP_REG_MEM |=>
      flags_reg.carry == ($past(cmd_reg.working_register) <
                          $past(mem_rdata)) &&
      flags_reg.zero == ($past(cmd_reg.working_register) ==
                         $past(mem_rdata)))
    else $error("register-first compare flags wrong");
  AST_CMP_MEM_FIRST: assert property (
    exec && cmd_reg.op == OP_CMP_MEM_REG |=>
      flags_reg.carry == ($past(mem_rdata) <
                          $past(cmd_reg.working_register)) &&
      flags_reg.zero == ($past(mem_rdata) ==
                         $past(cmd_reg.working_register)))
    else $error("memory-first compare flags wrong");
  AST_CMP_NO_WRITE: assert property (
    exec && cmd_reg.op inside {OP_CMP_REG_MEM, OP_CMP_MEM_REG} |->
      !eng_wr ##1 (CMD_READY && DONE))
    else $error("compare wrote memory or did not finish");
  AST_IO_CLEAR: assert property (
    take && CMD.op == OP_BIT_CLEAR_OP_IO && !flag_bus_wr |=>
      !port_q[cmd_reg.port_sel][cmd_reg.bit_sel] &&
      ((port_q[cmd_reg.port_sel] ^ chk_port_before) & ~mask_exec)
        == 8'h00 && $stable(flags_reg))
    else $error("I/O bit clear wrong");
  AST_IO_SET: assert property (
    take && CMD.op == OP_BIT_FORCE_HIGH_OP_IO && !flag_bus_wr |=>
      port_q[cmd_reg.port_sel][cmd_reg.bit_sel] &&
      ((port_q[cmd_reg.port_sel] ^ chk_port_before) & ~mask_exec)
        == 8'h00 && $stable(flags_reg))
    else $error("I/O bit set wrong");
  AST_SWAP_ONLY_CARRY: assert property (
    take && CMD.op == OP_IO_SWAP_CARRY && !flag_bus_wr |=>
      $stable(flags_reg.zero) && $stable(flags_reg.half_carry_flag) &&
      $stable(flags_reg.signed_range_flag))
    else $error("swap changed a flag other than carry");
  AST_SWAP_OUTPUT: assert property (
    take && CMD.op == OP_IO_SWAP_CARRY &&
    dir_q[CMD.port_sel][CMD.bit_sel] |=>
      port_q[cmd_reg.port_sel][cmd_reg.bit_sel] ==
        $past(flags_reg.carry) &&
      flags_reg.carry == chk_port_before[cmd_reg.bit_sel])
    else $error("output swap did not exchange bit and carry");
  AST_SWAP_INPUT: assert property (
    take && CMD.op == OP_IO_SWAP_CARRY &&
    !dir_q[CMD.port_sel][CMD.bit_sel] |=>
      flags_reg.carry == $past(pin_q[CMD.port_sel][CMD.bit_sel]))
    else $error("input swap did not load the pin level");
  AST_MEM_SET: assert property (
    exec && cmd_reg.op == OP_BIT_FORCE_HIGH_OP_MEM && !flag_bus_wr |->
      eng_wr && eng_wdata[cmd_reg.bit_sel] &&
      ((eng_wdata ^ mem_rdata) & ~mask_exec) == 8'h00
      ##1 $stable(flags_reg))
    else $error("memory bit set wrong");
  AST_MEM_CLEAR: assert property (
    exec && cmd_reg.op == OP_BIT_CLEAR_OP_MEM && !flag_bus_wr |->
      eng_wr && !eng_wdata[cmd_reg.bit_sel] &&
      ((eng_wdata ^ mem_rdata) & ~mask_exec) == 8'h00
      ##1 $stable(flags_reg))
    else $error("memory bit clear wrong");
  AST_DIR_ENABLE: assert property (
    BUS_WR && BUS_ADDR == `NCBO_REG_FIRST_PORT_DIR |=>
      PIN_OE[0] == $past(BUS_WDATA))
    else $error("direction write did not reach the output enable");

  COV_NEG: cover property (exec && cmd_reg.op == OP_NEG_MEM);
  COV_CMP_BORROW: cover property (
    exec && cmd_reg.op == OP_CMP_REG_MEM ##1 flags_reg.carry);
  COV_SWAP_OUT: cover property (
    take && CMD.op == OP_IO_SWAP_CARRY && dir_q[CMD.port_sel][CMD.bit_sel]);
  COV_SWAP_IN: cover property (
    take && CMD.op == OP_IO_SWAP_CARRY &&
    !dir_q[CMD.port_sel][CMD.bit_sel]);

endmodule // ncbo_core

// ===== tb/ncbo_core_tb.sv
/*
  Self-checking bench for the negate, compare and bit-operation slice:
  register port tasks, command tasks and expected values per test.
  Assumes ncbo_pkg and ncbo_regs.svh are compiled and on the include path.
*/
`timescale 1ns/10ps
`include "ncbo_regs.svh"

module ncbo_core_tb
  import ncbo_pkg::*;
;
  logic                           CLK;
  logic                           RST_N;
  logic                           CMD_VALID;
  ncbo_cmd_t                      CMD;
  logic                           CMD_READY;
  logic                           DONE;
  ncbo_flags_t                    FLAGS;
  logic [8:0]                     BUS_ADDR;
  logic [7:0]                     BUS_WDATA;
  logic                           BUS_WR;
  logic                           BUS_RD;
  logic [7:0]                     BUS_RDATA;
  logic [NCBO_NPORT-1:0][7:0]     PIN_IN;
  logic [NCBO_NPORT-1:0][7:0]     PIN_OUT;
  logic [NCBO_NPORT-1:0][7:0]     PIN_OE;
  int                             n_mismatch;
  int                             checks;
  logic [7:0]                     am [3];
  logic [7:0]                     mm [3];

  ncbo_core #(.MEM_AW(6)) ncbo_core_inst (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .CMD_VALID (CMD_VALID),
    .CMD       (CMD),
    .CMD_READY (CMD_READY),
    .DONE      (DONE),
    .FLAGS     (FLAGS),
    .BUS_ADDR  (BUS_ADDR),
    .BUS_WDATA (BUS_WDATA),
    .BUS_WR    (BUS_WR),
    .BUS_RD    (BUS_RD),
    .BUS_RDATA (BUS_RDATA),
    .PIN_IN    (PIN_IN),
    .PIN_OUT   (PIN_OUT),
    .PIN_OE    (PIN_OE)
  );

  initial begin
    CLK = 1'b0;
  end

  always begin
    #5 CLK = ~CLK;
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge CLK);
    BUS_WR    <= 1'b1;
    BUS_ADDR  <= a;
    BUS_WDATA <= d;
    @(posedge CLK);
    BUS_WR    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [8:0] a,
                        input logic [7:0] exp);
    @(posedge CLK);
    BUS_RD   <= 1'b1;
    BUS_ADDR <= a;
    @(posedge CLK);
    BUS_RD   <= 1'b0;
    #1;
    check(what, exp, BUS_RDATA);
    @(posedge CLK);
    #1;
    check("read data cleared", 8'h00, BUS_RDATA);
  endtask

  // lat is the count of extra edges after the take edge before DONE
  task automatic run_cmd(input ncbo_op_t op, input logic ps,
                         input logic [2:0] b, input logic [7:0] ma,
                         input logic [7:0] wr, input int lat);
    int n;
    n = 0;
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD       <= '{op, ps, b, ma, wr};
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    #1;
    check("ready after take", 8'(lat == 0), 8'(CMD_READY));
    while (DONE !== 1'b1 && n < 4) begin
      @(posedge CLK);
      #1;
      n++;
    end
    check("done latency", 8'(lat), 8'(n));
    @(posedge CLK);
    #1;
    check("done pulse", 8'h00, 8'(DONE));
  endtask

  function automatic logic [7:0] cmp_f(input logic [7:0] x,
                                       input logic [7:0] y);
    logic [7:0] r;
    r = x - y;
    return {4'h0, (x[7] ^ y[7]) & (x[7] ^ r[7]), x[3:0] < y[3:0],
            x < y, x == y};
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(5000 * 10);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    n_mismatch = 0;
    checks     = 0;
    RST_N      = 1'b0;
    CMD_VALID  = 1'b0;
    CMD        = '0;
    BUS_ADDR   = 9'h000;
    BUS_WDATA  = 8'h00;
    BUS_WR     = 1'b0;
    BUS_RD     = 1'b0;
    PIN_IN     = '0;
    am = '{8'h38, 8'h38, 8'h80};
    mm = '{8'h38, 8'h42, 8'h01};
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    #1;
    check("ready after reset", 8'h01, 8'(CMD_READY));
    check("pin out after reset", 8'h00, PIN_OUT[0]);
    check("pin oe after reset", 8'h00, PIN_OE[1]);
    rd_chk("flags after reset", `NCBO_REG_FLAGS, 8'h00);
    bus_wr(`NCBO_REG_FIRST_PORT_DIR, 8'h5A);
    rd_chk("first dir", `NCBO_REG_FIRST_PORT_DIR, 8'h5A);
    check("first oe", 8'h5A, PIN_OE[0]);
    rd_chk("unmapped", 9'h010, 8'h00);
    rd_chk("status idle", `NCBO_REG_STATUS, 8'h00);
    bus_wr(`NCBO_REG_FIRST_PORT_PIN, 8'h55);
    rd_chk("pin reg read only", `NCBO_REG_FIRST_PORT_PIN, 8'h00);
    $display("test registers done");

    bus_wr(9'h103, 8'h38);
    bus_wr(`NCBO_REG_FLAGS, 8'h0E);
    run_cmd(OP_NEG_MEM, 1'b0, 3'h0, 8'h03, 8'h00, 1);
    rd_chk("neg result", 9'h103, 8'hC8);
    rd_chk("neg flags", `NCBO_REG_FLAGS, 8'h0E);
    bus_wr(9'h104, 8'h00);
    run_cmd(OP_NEG_MEM, 1'b0, 3'h0, 8'h04, 8'h00, 1);
    rd_chk("neg zero result", 9'h104, 8'h00);
    rd_chk("neg zero flags", `NCBO_REG_FLAGS, 8'h0F);
    $display("test negate done");

    for (int i = 0; i < 3; i++) begin
      bus_wr(9'h105, mm[i]);
      run_cmd(OP_CMP_REG_MEM, 1'b0, 3'h0, 8'h05, am[i], 1);
      rd_chk("cmp rf", `NCBO_REG_FLAGS, cmp_f(am[i], mm[i]));
      rd_chk("cmp reg mem", 9'h105, mm[i]);
      run_cmd(OP_CMP_MEM_REG, 1'b0, 3'h0, 8'h05, am[i], 1);
      rd_chk("cmp mf", `NCBO_REG_FLAGS, cmp_f(mm[i], am[i]));
      rd_chk("cmp mem mem", 9'h105, mm[i]);
    end
    $display("test compare done");

    bus_wr(`NCBO_REG_FIRST_PORT_DATA, 8'hFF);
    bus_wr(`NCBO_REG_FLAGS, 8'h0B);
    run_cmd(OP_BIT_CLEAR_OP_IO, 1'b0, 3'h3, 8'h00, 8'h00, 0);
    check("io clear", 8'hF7, PIN_OUT[0]);
    rd_chk("io clear flags", `NCBO_REG_FLAGS, 8'h0B);
    bus_wr(`NCBO_REG_SECOND_PORT_DATA, 8'h00);
    run_cmd(OP_BIT_FORCE_HIGH_OP_IO, 1'b1, 3'h5, 8'h00, 8'h00, 0);
    check("io set", 8'h20, PIN_OUT[1]);
    rd_chk("io set reg", `NCBO_REG_SECOND_PORT_DATA, 8'h20);
    rd_chk("io set flags", `NCBO_REG_FLAGS, 8'h0B);
    $display("test io bits done");

    bus_wr(`NCBO_REG_FLAGS, 8'h09);
    run_cmd(OP_IO_SWAP_CARRY, 1'b0, 3'h1, 8'h00, 8'h00, 0);
    check("swap out pin", 8'hF5, PIN_OUT[0]);
    rd_chk("swap out flags", `NCBO_REG_FLAGS, 8'h0B);
    @(posedge CLK);
    PIN_IN[1] <= 8'h04;
    bus_wr(`NCBO_REG_FLAGS, 8'h09);
    repeat (3) @(posedge CLK);
    rd_chk("second pins", `NCBO_REG_SECOND_PORT_PIN, 8'h04);
    run_cmd(OP_IO_SWAP_CARRY, 1'b1, 3'h2, 8'h00, 8'h00, 0);
    rd_chk("swap in flags", `NCBO_REG_FLAGS, 8'h0B);
    check("swap in oe", 8'h00, PIN_OE[1]);
    $display("test carry swap done");

    bus_wr(9'h106, 8'h00);
    run_cmd(OP_BIT_FORCE_HIGH_OP_MEM, 1'b0, 3'h7, 8'h06, 8'h00, 1);
    rd_chk("mem set", 9'h106, 8'h80);
    rd_chk("mem set flags", `NCBO_REG_FLAGS, 8'h0B);
    bus_wr(9'h107, 8'hFF);
    run_cmd(OP_BIT_CLEAR_OP_MEM, 1'b0, 3'h0, 8'h07, 8'h00, 1);
    rd_chk("mem clear", 9'h107, 8'hFE);
    rd_chk("mem clear flags", `NCBO_REG_FLAGS, 8'h0B);
    check("flags port", 8'h0B, 8'(FLAGS));
    run_cmd(OP_NOP, 1'b0, 3'h0, 8'h00, 8'h00, 0);
    check("nop flags", 8'h0B, 8'(FLAGS));
    $display("test memory bits done");
    give_verdict();
  end
endmodule // ncbo_core_tb
